// [rtl/pp_pkg.sv]
// package: register map, mode coding, timing and carriers of the parallel port dma block
package pp_pkg;
    // register offsets from the device base
    localparam logic [4:0] OFS_INDIRECT = 5'h18;
    localparam logic [4:0] OFS_OUT_BUF  = 5'h1A;
    localparam logic [4:0] OFS_IN_MISC  = 5'h1C;
    localparam logic [4:0] OFS_CSR      = 5'h1E;
    // control/status field positions
    localparam int CSR_BUF_SEL = 2;
    localparam int CSR_IND_LO  = 3;
    localparam int CSR_EN_B    = 5;
    localparam int CSR_EN_A    = 6;
    localparam int CSR_FLUSH   = 11;
    localparam int CSR_MRST    = 14;
    // mode field bits and misc register address msbs
    localparam int MODE_LINE_A = 0;
    localparam int MODE_RX     = 1;
    localparam int MODE_SILO   = 2;
    localparam int MODE_DMA    = 3;
    localparam int MISC_MSB_S  = 14;
    localparam int MISC_MSB_P  = 15;
    localparam logic [3:0] MODE_RESET = 4'h0;
    // indirect register selector codes
    localparam logic [1:0] IND_ADDR_P = 2'h0;
    localparam logic [1:0] IND_WC_P   = 2'h1;
    localparam logic [1:0] IND_ADDR_S = 2'h2;
    localparam logic [1:0] IND_WC_S   = 2'h3;
    // timing
    localparam int CLK_MHZ     = 10;
    localparam int TIMEOUT_US  = 32;
    localparam int PULSE_US    = 1;
    localparam logic [8:0] TIMEOUT_CYC = 9'(TIMEOUT_US * CLK_MHZ);
    localparam logic [3:0] PULSE_CYC   = 4'(PULSE_US * CLK_MHZ);
    localparam logic [3:0] MRST_CYC    = 4'h8;
    // memory master carrier
    typedef struct packed {
        logic        npr;
        logic        msyn;
        logic        write;
        logic [16:0] addr;
        logic [15:0] wdata;
    } dma_port_s;
    // one address/count pair
    typedef struct packed {
        logic        msb;
        logic [15:0] addr;
        logic [15:0] wc;
        logic        done;
    } dma_buf_s;
    typedef enum logic [1:0] {DMA_IDLE, DMA_GRANT, DMA_CYCLE} dma_state_e;
endpackage

// [rtl/parallel_port_dma_control.sv]
// parallel port with silo and double-buffered dma to and from host memory
// Behaviour
// [R1] line A dma modes: A moves data, vector A
// [R2] line B dma modes: B moves data, vector B
// [R3] request edge: sample data, ack, fill silo
// [R4] buffer filled: toggle select, set its done
// [R5] buffer switch posts gated interrupt request
// [R6] new buffer runs only while done clear
// [R7] secondary count write clears secondary done
// [R8] primary done read-only, set by reset; the code also clears it on a primary count write
// [R9] bus error sets error, ends, interrupts
// [R10] halted after error until reset
// [R11] receive dma: input read gives last word
// [R12] transmit dma: written word goes next
// [R13] bit 7 follows A; B interrupts generally
// [R14] 17-bit word-aligned address, word count
// [R15] status bits 0,1 drive control lines
// [R16] two-bit indirect selector, reset zero
// [R17] select bit read-only, primary at reset
// [R18] functional mode: A rise interrupts vector A
// [R19] silo mode: each edge moves word, interrupts
// [R20] full receive silo withholds data-taken pulse
// [R21] empty transmit silo withholds new data
// [R22] software uses whole-word csr cycles only
// [R23] master reset bit runs, reads one, self-clears
// [R24] no ack or grant in 32us: error
// [R25] write-only mode register, functional at reset
// [R26] each word: address plus two, count minus one
`timescale 1ns/10ps
`default_nettype none
module parallel_port_dma_control #(
    parameter int SILO_DEPTH = 32 // words in the on-board silo
) (
    // clock and resets
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire logic               i_bus_init,
    // register port
    input  wire logic [4:0]         i_reg_addr,
    input  wire logic               i_reg_rd,
    input  wire logic               i_reg_wr,
    input  wire logic [15:0]        i_reg_wdata,
    output logic      [15:0]        o_reg_rdata,
    // user device lines
    input  wire logic [15:0]        i_user_data,
    input  wire logic               i_req_a,
    input  wire logic               i_req_b,
    output logic      [15:0]        o_user_data,
    output logic                    o_data_taken,
    output logic                    o_new_data_ready,
    output logic                    o_ctl0,
    output logic                    o_ctl1,
    // interrupt requests
    output logic                    o_irq_a,
    output logic                    o_irq_b,
    // memory master
    output pp_pkg::dma_port_s       o_dma,
    input  wire logic               i_dma_grant,
    input  wire logic               i_dma_ssyn,
    input  wire logic [15:0]        i_dma_rdata
);
    localparam int AW = $clog2(SILO_DEPTH);
    typedef logic [AW:0] cnt_t;
    localparam cnt_t FULL_CNT = cnt_t'(SILO_DEPTH);

    // control and status state
    logic [1:0]  ctl_q, ctl_d, ind_q, ind_d;
    logic        en_a_q, en_a_d, en_b_q, en_b_d, sel_q, sel_d, err_q, err_d;
    logic [3:0]  mrst_q, mrst_d, mode_q, mode_d;
    pp_pkg::dma_buf_s buf_q [2];
    pp_pkg::dma_buf_s buf_d [2];
    // user side state
    logic        req_a_q, req_b_q, pend_q, pend_d, ins_v_q, ins_v_d;
    logic [15:0] out_q, out_d, in_q, in_d, ins_q, ins_d, rdata_q, rdata_d;
    logic [3:0]  dt_q, dt_d, ndr_q, ndr_d;
    logic        dt_on_q, ndr_on_q; // pulse lines in flops, no gate after them
    logic        irq_a_q, irq_a_d, irq_b_q, irq_b_d;
    // dma master state
    pp_pkg::dma_port_s  dma_q, dma_d;
    pp_pkg::dma_state_e st_q, st_d;
    logic [8:0]  tmo_q, tmo_d;
    // silo
    logic [15:0] silo_mem [SILO_DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    cnt_t        cnt_q, cnt_d;
    logic        push, pop, post, fin;
    logic [15:0] push_data;

    // mode decode
    wire logic is_dma  = mode_q[pp_pkg::MODE_DMA];
    wire logic is_silo = mode_q[pp_pkg::MODE_SILO];
    wire logic is_rx   = mode_q[pp_pkg::MODE_RX];
    wire logic line_a  = mode_q[pp_pkg::MODE_LINE_A];
    wire logic funct   = !is_dma && !is_silo;
    // request edges; pins are synchronous so one stage suffices
    wire logic rise_a  = i_req_a && !req_a_q;
    wire logic rise_b  = i_req_b && !req_b_q;
    wire logic xedge   = line_a ? (i_req_a ^ req_a_q) : (i_req_b ^ req_b_q); // [R3]
    // master reset, bus init and i_rst all initialise
    wire logic init_all = i_rst || i_bus_init || (mrst_q != 4'h0);
    wire logic [15:0] head = silo_mem[rp_q];
    pp_pkg::dma_buf_s act;
    assign act = buf_q[sel_q];

    // word address: msb above 16 low bits, bit 0 always zero
    function automatic logic [16:0] word_addr(input pp_pkg::dma_buf_s b);
        word_addr = {b.msb, b.addr[15:1], 1'b0}; // [R14]
    endfunction

    // next state of everything but the silo words
    always_comb begin
        ctl_d = ctl_q; ind_d = ind_q; en_a_d = en_a_q; en_b_d = en_b_q;
        sel_d = sel_q; err_d = err_q; mode_d = mode_q; buf_d = buf_q;
        out_d = out_q; in_d = in_q; ins_d = ins_q; ins_v_d = ins_v_q;
        rdata_d = rdata_q; dma_d = dma_q; st_d = st_q; tmo_d = tmo_q;
        wp_d = wp_q; rp_d = rp_q; cnt_d = cnt_q; pend_d = pend_q;
        push = 1'b0; pop = 1'b0; post = 1'b0; fin = 1'b0;
        push_data = i_user_data;
        irq_a_d = 1'b0; irq_b_d = 1'b0;
        dt_d = (dt_q != 4'h0) ? dt_q - 4'h1 : 4'h0;
        ndr_d = (ndr_q != 4'h0) ? ndr_q - 4'h1 : 4'h0;
        mrst_d = (mrst_q != 4'h0) ? mrst_q - 4'h1 : 4'h0; // [R23]
        // register writes
        if (i_reg_wr && !init_all) begin
            unique case (i_reg_addr)
                pp_pkg::OFS_CSR: begin
                    ctl_d = i_reg_wdata[1:0]; // [R15]
                    ind_d = i_reg_wdata[pp_pkg::CSR_IND_LO +: 2]; // [R16]
                    en_b_d = i_reg_wdata[pp_pkg::CSR_EN_B]; // [R5]
                    en_a_d = i_reg_wdata[pp_pkg::CSR_EN_A];
                    if (i_reg_wdata[pp_pkg::CSR_FLUSH]) begin
                        wp_d = '0; rp_d = '0; cnt_d = '0;
                    end
                    if (i_reg_wdata[pp_pkg::CSR_MRST]) begin
                        mrst_d = pp_pkg::MRST_CYC; // [R23]
                    end
                end
                pp_pkg::OFS_OUT_BUF: begin
                    if (is_silo && !is_rx) begin
                        push = cnt_q != FULL_CNT; // silo transmit load
                        push_data = i_reg_wdata;
                    end else if (is_dma && !is_rx) begin
                        ins_d = i_reg_wdata; // [R12]
                        ins_v_d = 1'b1;
                    end else begin
                        out_d = i_reg_wdata;
                        ndr_d = pp_pkg::PULSE_CYC;
                    end
                end
                pp_pkg::OFS_IN_MISC: begin
                    mode_d = i_reg_wdata[3:0]; // [R25]
                    buf_d[0].msb = i_reg_wdata[pp_pkg::MISC_MSB_P];
                    buf_d[1].msb = i_reg_wdata[pp_pkg::MISC_MSB_S];
                end
                pp_pkg::OFS_INDIRECT: begin
                    unique case (ind_q)
                        pp_pkg::IND_ADDR_P: buf_d[0].addr = i_reg_wdata;
                        pp_pkg::IND_WC_P: begin
                            buf_d[0].wc = i_reg_wdata;
                            buf_d[0].done = 1'b0; // [R8]
                        end
                        pp_pkg::IND_ADDR_S: buf_d[1].addr = i_reg_wdata;
                        pp_pkg::IND_WC_S: begin
                            buf_d[1].wc = i_reg_wdata;
                            buf_d[1].done = 1'b0; // [R7]
                        end
                    endcase
                end
                default: ;
            endcase
        end
        // register reads; csr stays readable during master reset
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                pp_pkg::OFS_CSR: rdata_d = {req_b_q, mrst_q != 4'h0, err_q, 3'h0,
                    buf_q[1].done, buf_q[0].done, req_a_q, en_a_q, en_b_q, ind_q,
                    sel_q, ctl_q}; // [R13] [R17]
                pp_pkg::OFS_OUT_BUF: rdata_d = out_q;
                pp_pkg::OFS_IN_MISC: begin
                    if (is_silo && is_rx) begin
                        rdata_d = (cnt_q != '0) ? head : 16'h0000;
                        pop = cnt_q != '0;
                    end else if (is_dma && is_rx) begin
                        rdata_d = in_q; // [R11]
                    end else begin
                        rdata_d = i_user_data;
                        dt_d = pp_pkg::PULSE_CYC;
                    end
                end
                pp_pkg::OFS_INDIRECT: begin
                    unique case (ind_q)
                        pp_pkg::IND_ADDR_P: rdata_d = buf_q[0].addr;
                        pp_pkg::IND_WC_P:   rdata_d = buf_q[0].wc;
                        pp_pkg::IND_ADDR_S: rdata_d = buf_q[1].addr;
                        pp_pkg::IND_WC_S:   rdata_d = buf_q[1].wc;
                    endcase
                end
                default: rdata_d = 16'h0000; // unmapped reads as zero
            endcase
        end
        // transfer line: one edge is held until the silo can serve it
        if (!funct && xedge) begin
            pend_d = 1'b1; // [R1] [R2]
        end
        if (!funct && pend_q) begin
            if (is_rx) begin
                if (cnt_q != FULL_CNT) begin // [R20]
                    push = 1'b1; // [R3]
                    push_data = i_user_data;
                    dt_d = pp_pkg::PULSE_CYC;
                    pend_d = 1'b0;
                    post = is_silo; // [R19]
                end
            end else if (ins_v_q) begin
                out_d = ins_q; // [R12]
                ins_v_d = 1'b0;
                ndr_d = pp_pkg::PULSE_CYC;
                pend_d = 1'b0;
            end else if (cnt_q != '0) begin // [R21]
                pop = 1'b1;
                out_d = head;
                ndr_d = pp_pkg::PULSE_CYC;
                pend_d = 1'b0;
                post = is_silo; // [R19]
            end
        end
        // dma master; halted by error or a done buffer
        unique case (st_q)
            pp_pkg::DMA_IDLE: begin
                tmo_d = 9'h000;
                if (is_dma && !err_q && !act.done && act.wc != 16'h0000 // [R6] [R10]
                        && (is_rx ? cnt_q != '0 : cnt_q != FULL_CNT && !push)) begin
                    dma_d.npr = 1'b1;
                    st_d = pp_pkg::DMA_GRANT;
                end
            end
            pp_pkg::DMA_GRANT: begin
                tmo_d = tmo_q + 9'h001;
                if (i_dma_grant) begin
                    dma_d.npr = 1'b0;
                    dma_d.msyn = 1'b1;
                    dma_d.write = is_rx;
                    dma_d.addr = word_addr(act); // [R14]
                    dma_d.wdata = head;
                    tmo_d = 9'h000;
                    st_d = pp_pkg::DMA_CYCLE;
                end
            end
            pp_pkg::DMA_CYCLE: begin
                tmo_d = tmo_q + 9'h001;
                if (i_dma_ssyn) begin
                    dma_d.msyn = 1'b0;
                    st_d = pp_pkg::DMA_IDLE;
                    if (is_rx) begin
                        pop = 1'b1;
                        in_d = head; // [R11]
                    end else begin
                        push = 1'b1;
                        push_data = i_dma_rdata;
                    end
                    {buf_d[sel_q].msb, buf_d[sel_q].addr} =
                        {act.msb, act.addr} + 17'h00002; // [R26]
                    buf_d[sel_q].wc = act.wc - 16'h0001;
                    fin = act.wc == 16'h0001;
                end
            end
        endcase
        if (st_q != pp_pkg::DMA_IDLE && !fin && tmo_q == pp_pkg::TIMEOUT_CYC - 9'h001
                && !(st_q == pp_pkg::DMA_GRANT ? i_dma_grant : i_dma_ssyn)) begin
            err_d = 1'b1; // [R24] [R9]
            dma_d.npr = 1'b0;
            dma_d.msyn = 1'b0;
            st_d = pp_pkg::DMA_IDLE;
            sel_d = !sel_q;
            post = 1'b1;
        end
        if (fin) begin
            buf_d[sel_q].done = 1'b1; // [R4]
            sel_d = !sel_q;
            post = 1'b1; // [R5]
        end
        // silo pointers
        if (push) begin
            wp_d = wp_d + AW'(1);
        end
        if (pop) begin
            rp_d = rp_d + AW'(1);
        end
        cnt_d = cnt_d + cnt_t'(push) - cnt_t'(pop);
        // interrupt routing: transfer line events go to its vector
        if (funct) begin
            irq_a_d = rise_a && en_a_q; // [R18]
            irq_b_d = rise_b && en_b_q;
        end else begin
            irq_a_d = line_a ? post && en_a_q : rise_a && en_a_q; // [R1] [R13]
            irq_b_d = line_a ? rise_b && en_b_q : post && en_b_q; // [R2] [R5]
        end
        // initialisation overrides everything else but the read data, the inserted word and the master reset countdown
        if (init_all) begin
            ctl_d = 2'h0; ind_d = 2'h0; en_a_d = 1'b0; en_b_d = 1'b0;
            sel_d = 1'b0; err_d = 1'b0; mode_d = pp_pkg::MODE_RESET; // [R17]
            buf_d[0] = '0; buf_d[1] = '0;
            buf_d[0].done = 1'b1; buf_d[1].done = 1'b1; // [R8]
            out_d = 16'h0000; in_d = 16'h0000; ins_v_d = 1'b0; pend_d = 1'b0;
            dma_d = '0; st_d = pp_pkg::DMA_IDLE; tmo_d = 9'h000;
            wp_d = '0; rp_d = '0; cnt_d = '0; dt_d = 4'h0; ndr_d = 4'h0;
            irq_a_d = 1'b0; irq_b_d = 1'b0; push = 1'b0;
        end
        if (i_rst || i_bus_init) begin
            mrst_d = 4'h0;
        end
    end

    // register stage
    always_ff @(posedge i_clk_sys) begin
        ctl_q <= ctl_d; ind_q <= ind_d; en_a_q <= en_a_d; en_b_q <= en_b_d;
        sel_q <= sel_d; err_q <= err_d; mrst_q <= mrst_d; mode_q <= mode_d;
        buf_q <= buf_d; out_q <= out_d; in_q <= in_d; ins_q <= ins_d;
        ins_v_q <= ins_v_d; rdata_q <= rdata_d; dma_q <= dma_d; st_q <= st_d;
        tmo_q <= tmo_d; wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d;
        pend_q <= pend_d; dt_q <= dt_d; ndr_q <= ndr_d;
        dt_on_q <= dt_d != 4'h0;
        ndr_on_q <= ndr_d != 4'h0;
        irq_a_q <= irq_a_d; irq_b_q <= irq_b_d;
        req_a_q <= i_req_a; req_b_q <= i_req_b;
    end

    // silo words need no reset; pointers guard them
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            silo_mem[wp_q] <= push_data;
        end
    end

    // outputs, all from flops
    assign o_reg_rdata = rdata_q;
    assign o_user_data = out_q;
    assign o_data_taken = dt_on_q;
    assign o_new_data_ready = ndr_on_q;
    assign o_ctl0 = ctl_q[0]; // [R15]
    assign o_ctl1 = ctl_q[1];
    assign o_irq_a = irq_a_q;
    assign o_irq_b = irq_b_q;
    assign o_dma = dma_q;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    ctl_line_a: assert property (i_reg_wr && i_reg_addr == pp_pkg::OFS_CSR && !init_all // [R15]
        |=> o_ctl0 == $past(i_reg_wdata[0])) else $error("control line wrong");
    sel_done_a: assert property (!$past(init_all) && $changed(sel_q) // [R4]
        |-> buf_q[$past(sel_q)].done || err_q) else $error("switch without flag");
    wc_clear_a: assert property (i_reg_wr && i_reg_addr == pp_pkg::OFS_INDIRECT // [R7]
        && ind_q == pp_pkg::IND_WC_S && !init_all && !fin |=> !buf_q[1].done)
        else $error("secondary done not cleared");
    err_halt_a: assert property (err_q |-> !o_dma.npr && !o_dma.msyn // [R10]
        && st_q == pp_pkg::DMA_IDLE) else $error("dma runs after error");
    tmo_bound_a: assert property (st_q != pp_pkg::DMA_IDLE // [R24]
        |-> tmo_q < pp_pkg::TIMEOUT_CYC) else $error("timeout overrun");
    rx_full_a: assert property (is_silo && is_rx && cnt_q == FULL_CNT && !pop // [R20]
        && !init_all |=> dt_q != pp_pkg::PULSE_CYC) else $error("ack while full");
    tx_empty_a: assert property (is_silo && !is_rx && cnt_q == '0 && !init_all // [R21]
        |=> ndr_q != pp_pkg::PULSE_CYC) else $error("data while empty");
    mrst_end_a: assert property (mrst_q == 4'h1 && !i_bus_init // [R23]
        |=> mrst_q == 4'h0 && mode_q == pp_pkg::MODE_RESET) else $error("reset stuck");
    init_val_a: assert property (init_all |=> !sel_q && buf_q[0].done // [R17]
        && buf_q[1].done && ind_q == 2'h0) else $error("bad init values");
    fun_irq_a: assert property (funct && rise_a && en_a_q && !init_all // [R18]
        |=> o_irq_a) else $error("missing vector a request");
endmodule
`default_nettype wire

// [test/pp_mem_model.sv]
// memory slave model answering the block's dma master port
`timescale 1ns/10ps
`default_nettype none
module pp_mem_model (
    // clock
    input  wire logic              i_clk_sys,
    // master side of the block
    input  wire pp_pkg::dma_port_s i_dma,
    input  wire logic              i_stall,
    output logic                   o_grant,
    output logic                   o_ssyn,
    output logic      [15:0]       o_rdata,
    // record of accepted writes
    output logic      [16:0]       o_last_addr,
    output logic      [15:0]       o_last_data,
    output logic      [7:0]        o_writes
);
    // stall withholds grant and ack so the block's timeout must fire
    initial begin
        o_grant = 1'b0;
        o_ssyn = 1'b0;
        o_rdata = 16'h0000;
        o_last_addr = 17'h00000;
        o_last_data = 16'h0000;
        o_writes = 8'h00;
    end
    always @(posedge i_clk_sys) begin
        // grant held from request until the cycle ends
        o_grant <= !i_stall && (i_dma.npr || (i_dma.msyn && o_grant));
        // one-cycle ack after sync, released with it
        o_ssyn <= !i_stall && i_dma.msyn && !o_ssyn;
        // read lines carry no meaning outside an ack, so keep them moving
        o_rdata <= ~o_rdata;
        if (!i_stall && i_dma.msyn && !o_ssyn && i_dma.write) begin
            o_last_addr <= i_dma.addr;
            o_last_data <= i_dma.wdata;
            o_writes <= o_writes + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [test/parallel_port_dma_control_tb.sv]
// self-checking bench for the parallel port dma block
`timescale 1ns/10ps
`default_nettype none
module parallel_port_dma_control_tb;
    logic              i_clk_sys = 1'b0;
    logic              i_rst = 1'b1;
    logic              i_bus_init = 1'b0;
    logic [4:0]        i_reg_addr = 5'h00;
    logic              i_reg_rd = 1'b0;
    logic              i_reg_wr = 1'b0;
    logic [15:0]       i_reg_wdata = 16'h0000;
    logic [15:0]       i_user_data = 16'h0000;
    logic              i_req_a = 1'b0;
    logic              i_req_b = 1'b0;
    logic              stall = 1'b0;      // memory never answers when set
    logic [15:0]       o_reg_rdata, o_user_data, rdata, last_data, mrd;
    logic              o_data_taken, o_ndr, o_ctl0, o_ctl1, o_irq_a, o_irq_b;
    logic              grant, ssyn;
    logic [16:0]       last_addr;
    logic [7:0]        writes;
    pp_pkg::dma_port_s dma;
    int                err_count = 0, tests_run = 0, irq_a_n = 0, irq_b_n = 0, ndr_n = 0;
    // clock, interrupt pulse and ready-cycle counters
    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (o_ndr === 1'b1) ndr_n++;
        if (o_irq_a === 1'b1) irq_a_n++;
        if (o_irq_b === 1'b1) irq_b_n++;
    end
    parallel_port_dma_control i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_bus_init(i_bus_init), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_user_data(i_user_data), .i_req_a(i_req_a), .i_req_b(i_req_b),
        .o_user_data(o_user_data), .o_data_taken(o_data_taken),
        .o_new_data_ready(o_ndr), .o_ctl0(o_ctl0), .o_ctl1(o_ctl1), .o_irq_a(o_irq_a),
        .o_irq_b(o_irq_b), .o_dma(dma), .i_dma_grant(grant), .i_dma_ssyn(ssyn),
        .i_dma_rdata(mrd));
    pp_mem_model i_mem (.i_clk_sys(i_clk_sys), .i_dma(dma), .i_stall(stall),
        .o_grant(grant), .o_ssyn(ssyn), .o_rdata(mrd), .o_last_addr(last_addr),
        .o_last_data(last_data), .o_writes(writes));
    // one comparison, counted
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // whole-word register write, one strobe cycle
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    // register read, data registered at the edge that takes the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 rdata = o_reg_rdata;
    endtask
    // user device: new word, toggle line A, wait for the data-taken pulse
    task automatic send(input logic [15:0] d);
        @(posedge i_clk_sys);
        i_user_data <= d;
        i_req_a <= ~i_req_a;
        for (int i = 0; i < 40 && o_data_taken !== 1'b1; i++) @(posedge i_clk_sys);
        chk("data taken", 17'h1, {16'h0, o_data_taken});
        repeat (30) @(posedge i_clk_sys);
    endtask
    // bus init pulse between scenarios
    task automatic init_pulse;
        @(posedge i_clk_sys);
        i_bus_init <= 1'b1;
        @(posedge i_clk_sys);
        i_bus_init <= 1'b0;
    endtask
    // reset values, control lines, functional-mode interrupts
    task automatic t_functional;
        rd(pp_pkg::OFS_CSR);
        chk("csr reset", 17'h00300, {1'b0, rdata});
        wr(pp_pkg::OFS_CSR, 16'h0063);
        repeat (2) @(posedge i_clk_sys);
        chk("ctl lines", 17'h3, {15'h0, o_ctl1, o_ctl0});
        i_req_a <= 1'b1;
        i_req_b <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        chk("irq a", 17'd1, 17'(irq_a_n));
        chk("irq b", 17'd1, 17'(irq_b_n));
        rd(pp_pkg::OFS_CSR);
        chk("csr req", 17'h083E3, {1'b0, rdata});
        i_req_a <= 1'b0;
        i_req_b <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        chk("irq fall", 17'd1, 17'(irq_a_n));
        $display("test functional done");
    endtask
    // receive dma on line A through both buffers
    task automatic t_dma;
        init_pulse();
        wr(pp_pkg::OFS_IN_MISC, 16'h000B);
        wr(pp_pkg::OFS_CSR, 16'h0040);
        wr(pp_pkg::OFS_INDIRECT, 16'h1000);
        wr(pp_pkg::OFS_CSR, 16'h0048);
        wr(pp_pkg::OFS_INDIRECT, 16'h0002);
        chk("ctl after init", 17'h0, {15'h0, o_ctl1, o_ctl0});
        send(16'hA501);
        send(16'hA502);
        chk("writes", 17'd2, {9'h0, writes});
        chk("last addr", 17'h01002, last_addr);
        chk("last data", 17'h0A502, {1'b0, last_data});
        chk("irq switch", 17'd2, 17'(irq_a_n));
        rd(pp_pkg::OFS_CSR);
        chk("csr primary full", 17'h0034C, {1'b0, rdata});
        rd(pp_pkg::OFS_IN_MISC);
        chk("input buffer", 17'h0A502, {1'b0, rdata});
        send(16'hA503);
        chk("inhibited", 17'd2, {9'h0, writes});
        wr(pp_pkg::OFS_CSR, 16'h0050);
        wr(pp_pkg::OFS_INDIRECT, 16'h2000);
        wr(pp_pkg::OFS_CSR, 16'h0058);
        wr(pp_pkg::OFS_INDIRECT, 16'h0001);
        repeat (30) @(posedge i_clk_sys);
        chk("resumed", 17'd3, {9'h0, writes});
        chk("secondary addr", 17'h02000, last_addr);
        chk("irq secondary", 17'd3, 17'(irq_a_n));
        rd(pp_pkg::OFS_CSR);
        chk("csr secondary full", 17'h003D8, {1'b0, rdata});
        $display("test dma done");
    endtask
    // missing grant times out, halts until master reset
    task automatic t_error;
        init_pulse();
        stall <= 1'b1;
        wr(pp_pkg::OFS_IN_MISC, 16'h000B);
        wr(pp_pkg::OFS_CSR, 16'h0048);
        wr(pp_pkg::OFS_INDIRECT, 16'h0001);
        send(16'h5A01);
        repeat (340) @(posedge i_clk_sys);
        rd(pp_pkg::OFS_CSR);
        chk("csr error", {1'b0, 16'h224C | 16'(i_req_a) << 7}, {1'b0, rdata});
        chk("irq error", 17'd4, 17'(irq_a_n));
        stall <= 1'b0;
        send(16'h5A02);
        chk("halted", 17'd3, {9'h0, writes});
        wr(pp_pkg::OFS_CSR, 16'h4000);
        rd(pp_pkg::OFS_CSR);
        chk("reset busy", 17'h1, {16'h0, rdata[14]});
        repeat (12) @(posedge i_clk_sys);
        rd(pp_pkg::OFS_CSR);
        chk("csr cleared", {1'b0, 16'h0300 | 16'(i_req_a) << 7}, {1'b0, rdata});
        $display("test error done");
    endtask
    // silo transmit on A, then an inserted word on B in dma transmit
    task automatic t_tx;
        int n_a, n_b, n_r;
        init_pulse();
        wr(pp_pkg::OFS_IN_MISC, 16'h0005);
        wr(pp_pkg::OFS_CSR, 16'h0060);
        n_a = irq_a_n;
        n_r = ndr_n;
        i_req_a <= ~i_req_a;
        repeat (20) @(posedge i_clk_sys);
        chk("ndr while empty", 17'd0, 17'(ndr_n - n_r));
        wr(pp_pkg::OFS_OUT_BUF, 16'hC35A);
        repeat (20) @(posedge i_clk_sys);
        chk("ndr length", 17'(pp_pkg::PULSE_CYC), 17'(ndr_n - n_r));
        chk("silo word out", 17'h0C35A, {1'b0, o_user_data});
        chk("silo irq", 17'(n_a + 1), 17'(irq_a_n));
        init_pulse();
        wr(pp_pkg::OFS_IN_MISC, 16'h0008);
        wr(pp_pkg::OFS_CSR, 16'h0020);
        wr(pp_pkg::OFS_OUT_BUF, 16'h1234);
        n_b = irq_b_n;
        n_r = ndr_n;
        chk("inserted held", 17'h0, {1'b0, o_user_data});
        i_req_b <= ~i_req_b;
        repeat (20) @(posedge i_clk_sys);
        chk("inserted word", 17'h01234, {1'b0, o_user_data});
        chk("inserted ndr", 17'(pp_pkg::PULSE_CYC), 17'(ndr_n - n_r));
        chk("b transfer quiet", 17'(n_b), 17'(irq_b_n));
        $display("test transmit done");
    endtask
    // verdict, the single end of the run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: the tests need about 700 cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_count++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_functional();
        t_dma();
        t_error();
        t_tx();
        stop_test();
    end
endmodule
`default_nettype wire
